// [hw/ceat_map.vh]
// Register map, field layout and timing constants of the CE-ATA host sequencer
`ifndef CEAT_MAP_VH
`define CEAT_MAP_VH

// Controller register byte offsets
`define CEAT_A_CTRL      12'h000
`define CEAT_A_BLKSIZ    12'h01C
`define CEAT_A_BYTCNT    12'h020
`define CEAT_A_CMDARG    12'h028
`define CEAT_A_CMD       12'h02C
`define CEAT_A_CARDTHR   12'h100
`define CEAT_A_TFWIN     12'h110
`define CEAT_A_DATA      12'h200

// Command register fields
`define CEAT_CMD_START   31
`define CEAT_CMD_CCS     23
`define CEAT_CMD_RDCE    22
`define CEAT_CMD_STOP    14
`define CEAT_CMD_WPRV    13
`define CEAT_CMD_RW      10
`define CEAT_CMD_DEXP    9
`define CEAT_CMD_CRC     8
`define CEAT_CMD_RESP    6
`define CEAT_IDX_RW_REG  6'h3C
`define CEAT_IDX_RW_BLK  6'h3D
`define CEAT_IDX_STOP    6'h0C

// Control register fields
`define CEAT_CTRL_CCSD   10
`define CEAT_CTRL_ACCSD  9
`define CEAT_CTRL_FRST   1

// Threshold control fields
`define CEAT_THR_EN      0
`define CEAT_THR_POS     16

// Argument fields
`define CEAT_ARG_W       31
`define CEAT_ARG_CNT_POS 2
`define CEAT_ARG_IDENT   8'h80
`define CEAT_ARG_SMALL   8'h04

// Sizes and task-file values
`define CEAT_TF_BYTES    16'h0010
`define CEAT_IDENT_BYTES 16'h0200
`define CEAT_FIFO_WORDS  14'h0400
`define CEAT_ATA_IDENT   8'hEC
`define CEAT_ATA_STBY    8'hE0
`define CEAT_ATA_FLUSH   8'hEA
`define CEAT_TF_ERR      0
`define CEAT_TF_XWORDS   30'h0000_0003

// Request operation codes
`define CEAT_OP_IDENT    3'h0
`define CEAT_OP_RDEXT    3'h1
`define CEAT_OP_WREXT    3'h2
`define CEAT_OP_STBY     3'h3
`define CEAT_OP_FLUSH    3'h4

// Card clock idle time before reprogramming the threshold
`define CEAT_SYS_MHZ     125
`define CEAT_CLK_IDLE_NS 1000
`define CEAT_CLK_IDLE_CYC ((`CEAT_CLK_IDLE_NS * `CEAT_SYS_MHZ + 999) / 1000)

`endif

// [hw/ceat_fifo.v]
// Read-data FIFO with registered output stage
`timescale 1ns/100ps
`default_nettype none
module ceat_fifo #(
  parameter W     = 32,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire         clk_sys,
  input  wire         rst,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output reg          out_valid,
  input  wire         out_ready,
  output reg  [W-1:0] out_data
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr;
  reg [AW-1:0] rptr;
  reg [AW:0]   cnt;
  wire push;
  wire pop;

  assign in_ready = (cnt != DEPTH[AW:0]);
  assign push     = in_valid && in_ready;
  assign pop      = (cnt != {(AW+1){1'b0}}) && (!out_valid || out_ready);

  always @(posedge clk_sys)
  begin
    if (push)
      mem[wptr] <= in_data;
  end

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wptr      <= {AW{1'b0}};
      rptr      <= {AW{1'b0}};
      cnt       <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {W{1'b0}};
    end
    else
    begin
      if (push)
        wptr <= wptr + 1'b1;
      if (pop)
      begin
        rptr     <= rptr + 1'b1;
        out_data <= mem[rptr];
      end
      if (pop)
        out_valid <= 1'b1;
      else if (out_ready)
        out_valid <= 1'b0;
      cnt <= cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule
`default_nettype wire

// [hw/ceat_host_seq.v]
// CE-ATA command sequencer driving the card controller's registers
`timescale 1ns/100ps
`default_nettype none
`include "ceat_map.vh"
// Behaviour
// - Timeout with CCS expected: CCSD, wait, then end with no stop
// - Timeout without CCS: stop, then terminate
// - Identify only with 512-byte block size
// - Identify: register command, then block read
// - Identify register command field settings
// - Identify retrieval block command field settings
// - Read ext: register command, block data-in
// - Write ext: register command, block data-out
// - Standby register command settings, no block
// - Standby success only from status field
// - Flush register command settings, no block
// - Flush error: read other task-file fields
// - Program threshold and enable before reads
// - Threshold equals the transfer block size
// - Long round trip forces threshold enable
// - Enable only if block/4 within 1024
// - Threshold set before command, not mid-transfer
module ceat_host_seq #(
  parameter [7:0] ATA_RD_EXT = 8'h00,
  parameter [7:0] ATA_WR_EXT = 8'h00
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        req_valid,
  output wire        req_ready,
  input  wire [2:0]  req_op,
  input  wire [15:0] req_count,
  input  wire        req_ccs,
  input  wire [15:0] cfg_blk_size,
  input  wire        cfg_thr_en,
  input  wire        cfg_rtd_long,
  output reg         done,
  output reg         err,
  output reg  [31:0] res_status,
  output wire        rdat_valid,
  input  wire        rdat_ready,
  output wire [31:0] rdat_data,
  input  wire        wdat_valid,
  output wire        wdat_ready,
  input  wire [31:0] wdat_data,
  output reg         bus_wr,
  output reg         bus_rd,
  output reg  [11:0] bus_addr,
  output reg  [31:0] bus_wdata,
  input  wire [31:0] bus_rdata,
  input  wire        bus_ack,
  input  wire        dev_done,
  input  wire        io_read_delay_limit_tmo,
  input  wire        card_clk,
  output wire        card_clk_idle
);
  localparam S_IDLE = 3'd0;
  localparam S_STEP = 3'd1;
  localparam S_BUS  = 3'd2;
  localparam S_WAIT = 3'd3;
  localparam S_STR  = 3'd4;

  localparam K_SKIP = 3'd0;
  localparam K_WR   = 3'd1;
  localparam K_RD   = 3'd2;
  localparam K_WAIT = 3'd3;
  localparam K_RSTR = 3'd4;
  localparam K_WSTR = 3'd5;
  localparam K_END  = 3'd6;
  localparam K_THR  = 3'd7;

  reg  [2:0]  state;
  reg  [2:0]  op;
  reg  [3:0]  pc;
  reg         rec;
  reg         ccs_cur;
  reg         in_str;
  reg         tmo_pend;
  reg  [15:0] blk;
  reg  [15:0] cnt;
  reg  [29:0] words;
  reg  [2:0]  k;
  reg  [11:0] a;
  reg  [31:0] d;
  reg         c1;
  reg         c2;
  reg         c3;
  reg         clk_lvl;
  reg  [7:0]  idle_cnt;

  wire        fifo_ready;
  wire        push;
  wire        is_rd;
  wire        is_ext;
  wire        no_blk;
  wire        thr_en;
  wire [31:0] bytes;
  wire [31:0] cmd_base;
  reg  [7:0]  tf_cmd;

  assign is_rd    = (op == `CEAT_OP_IDENT) || (op == `CEAT_OP_RDEXT);
  assign is_ext   = (op == `CEAT_OP_RDEXT) || (op == `CEAT_OP_WREXT);
  assign no_blk   = (op == `CEAT_OP_STBY) || (op == `CEAT_OP_FLUSH);
  assign bytes    = {16'h0000, cnt} * {16'h0000, blk};
  assign cmd_base = (32'h0000_0001 << `CEAT_CMD_START) | (32'h0000_0001 << `CEAT_CMD_RESP)
                  | (32'h0000_0001 << `CEAT_CMD_CRC) | (32'h0000_0001 << `CEAT_CMD_WPRV);
  // Forced on by long round trip, only if one block fits the FIFO
  assign thr_en   = (cfg_thr_en || cfg_rtd_long)
                  && (blk[15:2] <= `CEAT_FIFO_WORDS);

  assign req_ready  = (state == S_IDLE);
  assign wdat_ready = (state == S_STR) && (k == K_WSTR) && (words != 30'h0000_0000);
  assign push       = (state == S_BUS) && bus_ack && bus_rd && in_str;
  assign card_clk_idle = ({24'h00_0000, idle_cnt} == `CEAT_CLK_IDLE_CYC);

  always @*
  begin
    case (op)
      `CEAT_OP_IDENT: tf_cmd = `CEAT_ATA_IDENT;
      `CEAT_OP_RDEXT: tf_cmd = ATA_RD_EXT;
      `CEAT_OP_WREXT: tf_cmd = ATA_WR_EXT;
      `CEAT_OP_STBY:  tf_cmd = `CEAT_ATA_STBY;
      `CEAT_OP_FLUSH: tf_cmd = `CEAT_ATA_FLUSH;
      default:        tf_cmd = 8'h00;
    endcase
  end

  // Step table: kind, address and data of the current step
  always @*
  begin
    k = K_SKIP;
    a = `CEAT_A_DATA;
    d = 32'h0000_0000;
    if (rec)
    begin
      case (pc)
        4'd0:
        begin
          k = K_WR;
          if (ccs_cur)
          begin
            a = `CEAT_A_CTRL;
            d = (32'h0000_0001 << `CEAT_CTRL_CCSD) | (32'h0000_0001 << `CEAT_CTRL_ACCSD);
          end
          else
          begin
            a = `CEAT_A_CMD;
            d = (cmd_base & ~(32'h0000_0001 << `CEAT_CMD_WPRV))
              | (32'h0000_0001 << `CEAT_CMD_STOP) | {26'h000_0000, `CEAT_IDX_STOP};
          end
        end
        4'd1: k = K_WAIT;
        4'd2:
        begin
          k = ccs_cur ? K_END : K_WR;
          a = `CEAT_A_CTRL;
          d = 32'h0000_0001 << `CEAT_CTRL_FRST;
        end
        default: k = K_END;
      endcase
    end
    else
    begin
      case (pc)
        4'd0:
        begin
          k = is_rd ? K_THR : K_SKIP;
          a = `CEAT_A_CARDTHR;
          d = ({19'h0_0000, blk[12:0]} << `CEAT_THR_POS)
            | ({31'h0000_0000, thr_en} << `CEAT_THR_EN);
        end
        4'd1:
        begin
          k = K_WR;
          a = `CEAT_A_BLKSIZ;
          d = {16'h0000, `CEAT_TF_BYTES};
        end
        4'd2:
        begin
          k = K_WR;
          a = `CEAT_A_BYTCNT;
          d = {16'h0000, `CEAT_TF_BYTES};
        end
        4'd3:
        begin
          k = K_WR;
          a = `CEAT_A_CMDARG;
          d = ({31'h0000_0000, !is_rd} << `CEAT_ARG_W)
            | ({24'h00_0000, (op == `CEAT_OP_IDENT) ? `CEAT_ARG_IDENT : `CEAT_ARG_SMALL}
               << `CEAT_ARG_CNT_POS);
        end
        4'd4, 4'd5: k = K_WR;
        4'd6:
        begin
          k = K_WR;
          d = is_ext ? {16'h0000, cnt} : 32'h0000_0000;
        end
        4'd7:
        begin
          k = K_WR;
          d = {24'h00_0000, tf_cmd};
        end
        4'd8:
        begin
          k = K_WR;
          a = `CEAT_A_CMD;
          d = cmd_base | {26'h000_0000, `CEAT_IDX_RW_REG};
        end
        4'd9: k = K_WAIT;
        4'd10:
        begin
          k = K_WR;
          a = no_blk ? `CEAT_A_TFWIN : `CEAT_A_BLKSIZ;
          d = {16'h0000, blk};
          if (no_blk)
            k = K_RD;
        end
        4'd11:
        begin
          k = K_WR;
          a = `CEAT_A_BYTCNT;
          d = bytes;
          if (no_blk)
          begin
            a = `CEAT_A_TFWIN;
            k = (op == `CEAT_OP_FLUSH) && res_status[`CEAT_TF_ERR] ? K_RSTR : K_END;
          end
        end
        4'd12:
        begin
          k = no_blk ? K_END : K_WR;
          a = `CEAT_A_CMDARG;
          d = ({31'h0000_0000, !is_rd} << `CEAT_ARG_W) | {16'h0000, cnt};
        end
        4'd13:
        begin
          k = K_WR;
          a = `CEAT_A_CMD;
          d = cmd_base | (32'h0000_0001 << `CEAT_CMD_DEXP)
            | ({31'h0000_0000, ccs_cur} << `CEAT_CMD_CCS)
            | ({31'h0000_0000, is_rd} << `CEAT_CMD_RDCE)
            | ({31'h0000_0000, !is_rd} << `CEAT_CMD_RW)
            | {26'h000_0000, `CEAT_IDX_RW_BLK};
        end
        4'd14: k = is_rd ? K_RSTR : K_WSTR;
        default: k = K_WAIT;
      endcase
    end
  end

  // Card clock watch: counts idle time between sampled edges
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      c1       <= 1'b0;
      c2       <= 1'b0;
      c3       <= 1'b0;
      clk_lvl  <= 1'b0;
      idle_cnt <= 8'h00;
    end
    else
    begin
      c1 <= card_clk;
      c2 <= c1;
      c3 <= c2;
      if (c2 == c3)
        clk_lvl <= c3;
      if ((c2 == c3) && (c3 != clk_lvl))
        idle_cnt <= 8'h00;
      else if (!card_clk_idle)
        idle_cnt <= idle_cnt + 8'h01;
    end
  end

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state      <= S_IDLE;
      op         <= `CEAT_OP_IDENT;
      pc         <= 4'h0;
      rec        <= 1'b0;
      ccs_cur    <= 1'b0;
      in_str     <= 1'b0;
      tmo_pend   <= 1'b0;
      blk        <= 16'h0000;
      cnt        <= 16'h0000;
      words      <= 30'h0000_0000;
      done       <= 1'b0;
      err        <= 1'b0;
      res_status <= 32'h0000_0000;
      bus_wr     <= 1'b0;
      bus_rd     <= 1'b0;
      bus_addr   <= 12'h000;
      bus_wdata  <= 32'h0000_0000;
    end
    else
    begin
      done <= 1'b0;
      if (io_read_delay_limit_tmo && (state != S_IDLE))
        tmo_pend <= 1'b1;
      case (state)
        S_IDLE:
        begin
          tmo_pend <= 1'b0;
          if (req_valid)
          begin
            op      <= req_op;
            pc      <= 4'h0;
            rec     <= 1'b0;
            ccs_cur <= (req_op == `CEAT_OP_IDENT) || req_ccs;
            blk     <= (req_op == `CEAT_OP_IDENT) ? `CEAT_IDENT_BYTES : cfg_blk_size;
            cnt     <= (req_op == `CEAT_OP_IDENT) ? 16'h0001 : req_count;
            if ((req_op == `CEAT_OP_IDENT) && (cfg_blk_size != `CEAT_IDENT_BYTES))
            begin
              done <= 1'b1;
              err  <= 1'b1;
            end
            else
            begin
              err   <= 1'b0;
              state <= S_STEP;
            end
          end
        end
        S_STEP:
        begin
          in_str    <= 1'b0;
          bus_addr  <= a;
          bus_wdata <= d;
          case (k)
            K_WR:
            begin
              bus_wr <= 1'b1;
              state  <= S_BUS;
            end
            K_THR:
            begin
              if (card_clk_idle)
              begin
                bus_wr <= 1'b1;
                state  <= S_BUS;
              end
            end
            K_RD:
            begin
              bus_rd <= 1'b1;
              state  <= S_BUS;
            end
            K_WAIT: state <= S_WAIT;
            K_RSTR, K_WSTR:
            begin
              words <= (rec || no_blk) ? `CEAT_TF_XWORDS : bytes[31:2];
              state <= S_STR;
            end
            K_END:
            begin
              done  <= 1'b1;
              state <= S_IDLE;
            end
            default: pc <= pc + 4'h1;
          endcase
        end
        S_BUS:
        begin
          if (bus_ack)
          begin
            bus_wr <= 1'b0;
            bus_rd <= 1'b0;
            if (in_str)
            begin
              words <= words - 30'h0000_0001;
              state <= S_STR;
            end
            else
            begin
              if (bus_rd)
                res_status <= bus_rdata;
              pc    <= pc + 4'h1;
              state <= S_STEP;
            end
          end
        end
        S_WAIT:
        begin
          if ((tmo_pend || io_read_delay_limit_tmo) && !rec)
          begin
            tmo_pend <= 1'b0;
            rec      <= 1'b1;
            err      <= 1'b1;
            pc       <= 4'h0;
            state    <= S_STEP;
          end
          else if (dev_done)
          begin
            if (!rec && (pc == 4'hF))
            begin
              done  <= 1'b1;
              state <= S_IDLE;
            end
            else
            begin
              pc    <= pc + 4'h1;
              state <= S_STEP;
            end
          end
        end
        S_STR:
        begin
          in_str <= 1'b1;
          if ((tmo_pend || io_read_delay_limit_tmo) && !rec && (k == K_RSTR) && !no_blk)
          begin
            tmo_pend <= 1'b0;
            rec      <= 1'b1;
            err      <= 1'b1;
            pc       <= 4'h0;
            state    <= S_STEP;
          end
          else if (words == 30'h0000_0000)
          begin
            pc    <= pc + 4'h1;
            state <= S_STEP;
          end
          else if ((k == K_RSTR) && fifo_ready)
          begin
            bus_rd <= 1'b1;
            state  <= S_BUS;
          end
          else if ((k == K_WSTR) && wdat_valid)
          begin
            bus_wdata <= wdat_data;
            bus_wr    <= 1'b1;
            state     <= S_BUS;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  ceat_fifo #(
    .W     (32),
    .DEPTH (16),
    .AW    (4)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (bus_rdata),
    .out_valid (rdat_valid),
    .out_ready (rdat_ready),
    .out_data  (rdat_data)
  );
endmodule
`default_nettype wire

// [verif/ceat_seq_chk_sva.sv]
// Port-level checker for the CE-ATA host sequencer
`timescale 1ns/100ps
`default_nettype none
`include "ceat_map.vh"
module ceat_seq_chk (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [2:0]  req_op,
  input wire logic [15:0] cfg_blk_size,
  input wire logic        done,
  input wire logic        err,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [11:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic        bus_ack,
  input wire logic        card_clk_idle
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic thr_seen;
  // Threshold written since the request was taken
  always @(posedge clk_sys or posedge rst)
    if (rst)
      thr_seen <= 1'b0;
    else if (req_valid && req_ready)
      thr_seen <= 1'b0;
    else if (bus_wr && bus_addr == `CEAT_A_CARDTHR)
      thr_seen <= 1'b1;
  sequence s_bad_ident;
    req_valid && req_ready && req_op == `CEAT_OP_IDENT && cfg_blk_size != 16'h0200;
  endsequence
  sequence s_refused;
    done && err ##1 !done;
  endsequence
  sequence s_blk_cmd;
    bus_wr && bus_addr == `CEAT_A_CMD && bus_wdata[5:0] == `CEAT_IDX_RW_BLK;
  endsequence
  chk_ident_refuse: assert property (s_bad_ident |=> s_refused)
    else $error("bad identify not refused");
  chk_ident_quiet: assert property (s_bad_ident |=> (!bus_wr && !bus_rd) [*2])
    else $error("bus used by refused identify");
  chk_bus_hold: assert property (bus_wr && !bus_ack |=> bus_wr && $stable(bus_addr)
    && $stable(bus_wdata)) else $error("write dropped before ack");
  chk_bus_drop: assert property ((bus_wr || bus_rd) && bus_ack |=> !bus_wr && !bus_rd)
    else $error("access held after ack");
  chk_one_access: assert property (!(bus_wr && bus_rd)) else $error("read and write together");
  chk_reg_nodata: assert property (bus_wr && bus_addr == `CEAT_A_CMD && bus_wdata[5:0] ==
    `CEAT_IDX_RW_REG |-> !bus_wdata[`CEAT_CMD_DEXP]) else $error("register command expects data");
  chk_blk_data: assert property (s_blk_cmd |-> bus_wdata[`CEAT_CMD_DEXP]
    && bus_wdata[`CEAT_CMD_RW] != bus_wdata[`CEAT_CMD_RDCE]) else $error("block command bits");
  chk_thr_before: assert property (s_blk_cmd ##0 bus_wdata[`CEAT_CMD_RDCE] |-> thr_seen)
    else $error("read block without threshold");
  chk_thr_idle: assert property ($rose(bus_wr) && bus_addr == `CEAT_A_CARDTHR |-> card_clk_idle)
    else $error("threshold written while card clock runs");
endmodule
`default_nettype wire

// [verif/ceat_ctl_model.sv]
// Behavioural card-controller model answering the sequencer's register accesses
`timescale 1ns/100ps
`default_nettype none
`include "ceat_map.vh"
module ceat_ctl_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [11:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  output logic      [31:0] bus_rdata,
  output logic             bus_ack,
  output logic             dev_done,
  output logic             io_read_delay_limit_tmo,
  output logic             card_clk
);
  logic [11:0] la[$];
  logic [31:0] ld[$];
  int          ack_wait = 3;
  logic        tmo_arm = 1'b0;
  logic [31:0] tf_status = 32'h0000_0050;
  int          n, words, need, dcnt;
  logic        pend, tsel, blk_go;
  initial card_clk = 1'b0;
  // Card clock bursts only after a block command, still otherwise
  always @(posedge blk_go)
    repeat (16) #62.5 card_clk = ~card_clk;
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      bus_ack <= 1'b0; dev_done <= 1'b0; io_read_delay_limit_tmo <= 1'b0; blk_go <= 1'b0;
      bus_rdata <= 32'h0000_0000; n <= 0; words <= 0; need <= 0; dcnt <= 0;
      pend <= 1'b0; tsel <= 1'b0;
    end
    else
    begin
      bus_ack <= 1'b0; blk_go <= 1'b0; bus_rdata <= ~bus_rdata;
      dev_done <= (dcnt == 1) && !tsel;
      io_read_delay_limit_tmo <= (dcnt == 1) && tsel;
      if (dcnt != 0) dcnt <= dcnt - 1;
      if (pend && words == need)
      begin
        dcnt <= 3; tsel <= 1'b0; pend <= 1'b0;
      end
      if ((bus_wr || bus_rd) && !bus_ack && n < ack_wait) n <= n + 1;
      else if ((bus_wr || bus_rd) && !bus_ack)
      begin
        n <= 0; bus_ack <= 1'b1;
        if (bus_rd) bus_rdata <= (bus_addr == `CEAT_A_DATA) ? 32'hA000_0000 + words : tf_status;
        if (bus_addr == `CEAT_A_DATA) words <= words + 1;
        if (bus_wr)
        begin
          la.push_back(bus_addr); ld.push_back(bus_wdata);
          if (bus_addr == `CEAT_A_BYTCNT) need <= bus_wdata >> 2;
          if (bus_addr == `CEAT_A_CMD && bus_wdata[5:0] == `CEAT_IDX_RW_BLK)
          begin
            words <= 0; blk_go <= 1'b1; pend <= !tmo_arm; tsel <= tmo_arm; dcnt <= tmo_arm ? 5 : 0;
          end
          else if (bus_addr == `CEAT_A_CMD || (bus_addr == `CEAT_A_CTRL && bus_wdata[`CEAT_CTRL_CCSD]))
          begin
            dcnt <= 6; tsel <= 1'b0;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Self-checking testbench for the CE-ATA host sequencer
`timescale 1ns/100ps
`default_nettype none
`include "ceat_map.vh"
module testbench;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid = 1'b0;
  logic [2:0]  req_op = 3'h0;
  logic [15:0] req_count = 16'h0001;
  logic        req_ccs = 1'b0;
  logic [15:0] cfg_blk_size = 16'h0200;
  logic        cfg_thr_en = 1'b1;
  logic        cfg_rtd_long = 1'b0;
  logic        rdat_ready = 1'b1;
  logic        wdat_valid = 1'b0;
  logic [15:0] wcnt = 16'h0000;
  logic        took = 1'b0;
  wire         req_ready, done, err, rdat_valid, wdat_ready, bus_wr, bus_rd, bus_ack;
  wire         dev_done, io_read_delay_limit_tmo, card_clk, card_clk_idle;
  wire  [31:0] res_status, rdat_data, bus_wdata, bus_rdata;
  wire  [11:0] bus_addr;
  logic [31:0] rq[$];
  int          mismatches = 0;
  int          samples_checked = 0;
  initial forever #4 clk_sys = ~clk_sys;
  ceat_host_seq dut (.clk_sys, .rst, .req_valid, .req_ready, .req_op, .req_count, .req_ccs,
    .cfg_blk_size, .cfg_thr_en, .cfg_rtd_long, .done, .err, .res_status, .rdat_valid,
    .rdat_ready, .rdat_data, .wdat_valid, .wdat_ready, .wdat_data({16'h0000, wcnt}), .bus_wr,
    .bus_rd, .bus_addr, .bus_wdata, .bus_rdata, .bus_ack, .dev_done, .io_read_delay_limit_tmo,
    .card_clk, .card_clk_idle);
  ceat_ctl_model ctl (.clk_sys, .rst, .bus_wr, .bus_rd, .bus_addr, .bus_wdata, .bus_rdata,
    .bus_ack, .dev_done, .io_read_delay_limit_tmo, .card_clk);
  always @(posedge clk_sys)
  begin
    took <= wdat_valid && wdat_ready;
    if (rdat_valid && rdat_ready) rq.push_back(rdat_data);
  end
  always @(negedge clk_sys) if (took) wcnt <= wcnt + 16'h0001;
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wchk(input int i, input logic [11:0] a, input logic [31:0] d);
    chk({20'h0_0000, ctl.la[i]}, {20'h0_0000, a}, "write address");
    chk(ctl.ld[i], d, "write data");
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task run(input logic [2:0] o, input logic [15:0] c, input logic s);
    int w;
    ctl.la.delete();
    ctl.ld.delete();
    @(negedge clk_sys);
    req_op = o; req_count = c; req_ccs = s; req_valid = 1'b1;
    @(negedge clk_sys) req_valid = 1'b0;
    w = 0;
    while (done !== 1'b1 && w < 20000)
    begin
      @(posedge clk_sys);
      #1 w++;
    end
    chk(w < 20000, 1, "done seen");
  endtask
  initial
  begin
    #400_000;
    mismatches++;
    print_verdict();
  end
  initial
  begin
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    chk({req_ready, done, err, rdat_valid, wdat_ready, bus_wr, bus_rd, card_clk_idle}, 8'h80,
      "reset outputs");
    for (int k = 0; k < 2; k++)
    begin
      ctl.tf_status = {31'h0000_0028, k[0]};
      rq.delete();
      run(k ? `CEAT_OP_FLUSH : `CEAT_OP_STBY, 16'h0001, 1'b0);
      wchk(0, `CEAT_A_BLKSIZ, 32'h0000_0010);
      wchk(1, `CEAT_A_BYTCNT, 32'h0000_0010);
      wchk(2, `CEAT_A_CMDARG, 32'h8000_0010);
      wchk(3, `CEAT_A_DATA, 32'h0000_0000);
      wchk(6, `CEAT_A_DATA, k ? 32'h0000_00EA : 32'h0000_00E0);
      wchk(7, `CEAT_A_CMD, 32'h8000_217C);
      chk(ctl.la.size(), 8, "write count");
      chk(res_status, ctl.tf_status, "status");
      chk(err, 0, "err");
      repeat (8) @(negedge clk_sys);
      chk(rq.size(), k ? 3 : 0, "task file words");
      if (k) chk(rq[2], ctl.tf_status, "task file word");
      $display("test status %0d ends", k);
    end
    cfg_blk_size = 16'h0400;
    run(`CEAT_OP_IDENT, 16'h0001, 1'b0);
    chk(err, 1, "refused err");
    chk(ctl.la.size(), 0, "refused writes");
    $display("test refuse ends");
    cfg_blk_size = 16'h0200;
    rq.delete();
    fork
      run(`CEAT_OP_IDENT, 16'h0001, 1'b0);
      begin
        @(negedge clk_sys) rdat_ready = 1'b0;
        repeat (900) @(negedge clk_sys);
        rdat_ready = 1'b1;
      end
    join
    repeat (8) @(negedge clk_sys);
    wchk(0, `CEAT_A_CARDTHR, 32'h0200_0001);
    wchk(1, `CEAT_A_BLKSIZ, 32'h0000_0010);
    wchk(3, `CEAT_A_CMDARG, 32'h0000_0200);
    wchk(7, `CEAT_A_DATA, 32'h0000_00EC);
    wchk(9, `CEAT_A_BLKSIZ, 32'h0000_0200);
    wchk(10, `CEAT_A_BYTCNT, 32'h0000_0200);
    wchk(11, `CEAT_A_CMDARG, 32'h0000_0001);
    chk({ctl.ld[12][`CEAT_CMD_CCS], ctl.ld[12][`CEAT_CMD_DEXP], ctl.ld[8][`CEAT_CMD_DEXP]},
      3'b110, "identify commands");
    chk(rq.size(), 128, "identify words");
    for (int i = 0; i < 128; i++) chk(rq[i], 32'hA000_0000 + i, "identify data");
    $display("test identify ends");
    for (int k = 0; k < 4; k++)
    begin
      cfg_blk_size = (k == 3) ? 16'h1004 : 16'h0200;
      cfg_thr_en = (k == 0 || k == 3);
      cfg_rtd_long = (k == 1);
      rq.delete();
      run(`CEAT_OP_RDEXT, 16'h0001, 1'b0);
      repeat (8) @(negedge clk_sys);
      wchk(0, `CEAT_A_CARDTHR, {3'h0, cfg_blk_size[12:0], 15'h0000, k < 2});
      wchk(11, `CEAT_A_CMDARG, 32'h0000_0001);
      chk({ctl.ld[12][`CEAT_CMD_RDCE], ctl.ld[12][`CEAT_CMD_RW]}, 2'b10, "read dir");
      chk(rq.size(), cfg_blk_size / 4, "read words");
      $display("test read %0d ends", k);
    end
    cfg_blk_size = 16'h0200;
    ctl.ack_wait = 0;
    @(negedge clk_sys) wdat_valid = 1'b1;
    run(`CEAT_OP_WREXT, 16'h0001, 1'b0);
    wdat_valid = 1'b0;
    ctl.ack_wait = 3;
    wchk(10, `CEAT_A_CMDARG, 32'h8000_0001);
    chk({ctl.ld[11][`CEAT_CMD_RDCE], ctl.ld[11][`CEAT_CMD_RW]}, 2'b01, "write dir");
    chk(ctl.la.size(), 140, "write length");
    for (int i = 0; i < 128; i++) wchk(12 + i, `CEAT_A_DATA, i);
    $display("test write ends");
    for (int k = 0; k < 2; k++)
    begin
      ctl.tmo_arm = 1'b1;
      run(`CEAT_OP_RDEXT, 16'h0001, k[0]);
      ctl.tmo_arm = 1'b0;
      chk(err, 1, "timeout err");
      if (k) wchk(13, `CEAT_A_CTRL, 32'h0000_0600);
      if (!k) wchk(13, `CEAT_A_CMD, 32'h8000_414C);
      if (!k) wchk(14, `CEAT_A_CTRL, 32'h0000_0002);
      $display("test timeout %0d ends", k);
    end
    print_verdict();
  end
endmodule
bind ceat_host_seq ceat_seq_chk u_chk (.clk_sys, .rst, .req_valid, .req_ready, .req_op,
  .cfg_blk_size, .done, .err, .bus_wr, .bus_rd, .bus_addr, .bus_wdata, .bus_ack, .card_clk_idle);
`default_nettype wire
